/* src/fpu_exc_unit.v */
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fpu_exc_regs.vh"

module fpu_exc_unit #(
    parameter ADDR_W = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output wire [1:0] bresp,
    output wire bvalid,
    input wire bready,
    input wire [ADDR_W-1:0] araddr,
    input wire arvalid,
    output wire arready,
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    output wire rvalid,
    input wire rready,
    input wire instr_valid,
    input wire [4:0] instr_op,
    input wire [2:0] instr_sti,
    input wire instr_wait,
    input wire [1:0] instr_dest_kind,
    input wire [5:0] arith_exc,
    input wire [15:0] load_cw,
    input wire [15:0] load_sw,
    input wire [15:0] load_tag,
    output wire instr_done,
    output wire trap_req,
    output wire indef_write,
    output wire [1:0] indef_kind,
    output wire store_valid,
    output wire [15:0] store_cw,
    output wire [15:0] store_sw,
    output wire [15:0] store_tag,
    output wire [15:0] status_word,
    output wire [15:0] control_word,
    output wire [15:0] tag_word,
    output wire irq
);

// ----------------------------------------
// helpers
// ----------------------------------------
function [1:0] tag_of;
    input [15:0] t;
    input [2:0] i;
    begin
        tag_of = t[{i, 1'b0} +: 2];
    end
endfunction

function is_arith;
    input [4:0] op;
    begin
        is_arith = (op == `OP_LOAD_FP) || (op == `OP_STP_FP) || (op == `OP_ARITH);
    end
endfunction

function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0] s;
    begin
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
endfunction

// ----------------------------------------
// state
// ----------------------------------------
reg [15:0] sw_r;
reg [15:0] cw_r;
reg [15:0] tag_r;
reg [15:0] sw_nxt;
reg [15:0] cw_nxt;
reg [15:0] tag_nxt;
reg done_r;
reg trap_r;
reg indef_r;
reg [1:0] indef_kind_r;
reg store_r;
reg trap_nxt;
reg indef_nxt;
reg store_nxt;
reg ovf;
reg unf;
reg arith_ev;
reg [2:0] top;
reg [2:0] dst;
reg [2:0] srci;
reg [1:0] t0;
reg [1:0] ti;
reg [`IRQ_W-1:0] irq_stat_r;
reg [`IRQ_W-1:0] irq_en_r;
reg irq_r;
reg awready_r;
reg wready_r;
reg bvalid_r;
reg [1:0] bresp_r;
reg arready_r;
reg rvalid_r;
reg [1:0] rresp_r;
reg [31:0] rdata_r;
reg [ADDR_W-1:0] aw_addr_r;
reg [ADDR_W-1:0] ar_addr_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;
wire wr_go;
wire rd_go;
wire wr_cw;
wire wr_clr;
wire wr_en;
wire wr_mapped;
wire masked;
wire chk_wait;
wire [`IRQ_W-1:0] ev;

assign wr_go = ~awready_r & ~wready_r & ~bvalid_r;
assign rd_go = ~arready_r & ~rvalid_r;
assign wr_cw = wr_go && (aw_addr_r == `REG_CONTROL);
assign wr_clr = wr_go && (aw_addr_r == `REG_IRQ_CLR);
assign wr_en = wr_go && (aw_addr_r == `REG_IRQ_EN);
assign wr_mapped = (aw_addr_r == `REG_STATUS) || (aw_addr_r == `REG_CONTROL) ||
    (aw_addr_r == `REG_TAGS) || (aw_addr_r == `REG_IRQ_STAT) ||
    (aw_addr_r == `REG_IRQ_CLR) || (aw_addr_r == `REG_IRQ_EN);
assign masked = cw_r[`CW_IM_BIT];
// only waiting ops look at pending exceptions
assign chk_wait = instr_wait || (instr_op == `OP_WAIT);

// ----------------------------------------
// instruction execution
// ----------------------------------------
always @* begin
    sw_nxt = sw_r;
    cw_nxt = cw_r;
    tag_nxt = tag_r;
    trap_nxt = 1'b0;
    indef_nxt = 1'b0;
    store_nxt = 1'b0;
    ovf = 1'b0;
    unf = 1'b0;
    arith_ev = 1'b0;
    top = sw_r[`SW_TOP_LO +: 3];
    dst = top - 3'd1;
    srci = top + instr_sti;
    t0 = tag_of(tag_r, top);
    ti = tag_of(tag_r, srci);
    if (wr_cw) begin
        cw_nxt = merge16(cw_r, wdata_r, wstrb_r);
    end
    if (instr_valid) begin
        if (chk_wait && sw_r[`SW_ES_BIT]) begin
            // pending unmasked exception serviced before the op runs
            trap_nxt = 1'b1;
        end else begin
            case (instr_op)
                `OP_LDCW: cw_nxt = load_cw;
                `OP_STCW, `OP_STSW, `OP_SAVE, `OP_XSAVE: store_nxt = 1'b1;
                `OP_RSTOR, `OP_XRSTOR: begin
                    cw_nxt = load_cw;
                    sw_nxt = load_sw;
                    tag_nxt = load_tag;
                end
                `OP_CLEX: begin
                    sw_nxt[5:0] = 6'h00;
                    sw_nxt[`SW_SF_BIT] = 1'b0;
                end
                `OP_INIT: begin
                    cw_nxt = `CW_INIT;
                    sw_nxt = 16'h0000;
                    tag_nxt = `TAG_ALL_EMPTY;
                end
                `OP_LEG_ENI, `OP_LEG_DISI, `OP_LEG_PM: begin
                    // legacy opcodes retire with no state change
                    sw_nxt = sw_r;
                end
                `OP_LOAD_EXT, `OP_LOAD_FP: begin
                    if (tag_of(tag_r, dst) != `TAG_EMPTY) begin
                        ovf = 1'b1;
                        if (masked) begin
                            sw_nxt[`SW_TOP_LO +: 3] = dst;
                            tag_nxt[{dst, 1'b0} +: 2] = `TAG_SPECIAL;
                        end
                    end else begin
                        sw_nxt[`SW_TOP_LO +: 3] = dst;
                        tag_nxt[{dst, 1'b0} +: 2] = `TAG_VALID;
                    end
                end
                `OP_STP_EXT, `OP_STP_FP: begin
                    unf = (t0 == `TAG_EMPTY);
                    if (!unf || masked) begin
                        sw_nxt[`SW_TOP_LO +: 3] = top + 3'd1;
                        tag_nxt[{top, 1'b0} +: 2] = `TAG_EMPTY;
                    end
                end
                `OP_ARITH: begin
                    unf = (t0 == `TAG_EMPTY) || (ti == `TAG_EMPTY);
                    if (!unf) begin
                        tag_nxt[{top, 1'b0} +: 2] = `TAG_VALID;
                    end else if (masked) begin
                        tag_nxt[{top, 1'b0} +: 2] = `TAG_SPECIAL;
                    end
                end
                `OP_XCHG: begin
                    unf = (t0 == `TAG_EMPTY) || (ti == `TAG_EMPTY);
                    if (!unf || masked) begin
                        // empties take the indefinite value, then swap
                        tag_nxt[{top, 1'b0} +: 2] = (ti == `TAG_EMPTY) ? `TAG_SPECIAL : ti;
                        tag_nxt[{srci, 1'b0} +: 2] = (t0 == `TAG_EMPTY) ? `TAG_SPECIAL : t0;
                    end
                end
                `OP_FREE: tag_nxt[{srci, 1'b0} +: 2] = `TAG_EMPTY;
                default: sw_nxt = sw_r;
            endcase
            if (ovf || unf) begin
                sw_nxt[`SW_IE_BIT] = 1'b1;
                sw_nxt[`SW_SF_BIT] = 1'b1;
                sw_nxt[`SW_C1_BIT] = ovf;
                if (masked) begin
                    indef_nxt = 1'b1;
                end else begin
                    // top and tags held at entry values
                    sw_nxt[`SW_TOP_LO +: 3] = top;
                    tag_nxt = tag_r;
                    trap_nxt = 1'b1;
                end
            end else if (is_arith(instr_op)) begin
                // stack-fault flag left as it was
                sw_nxt[5:0] = sw_r[5:0] | arith_exc;
                arith_ev = |(arith_exc & ~cw_r[5:0]);
            end
        end
    end
    // summary tracks unmasked sticky flags
    sw_nxt[`SW_ES_BIT] = |(sw_nxt[`EXC_CLASSES-1:0] & ~cw_nxt[`EXC_CLASSES-1:0]);
end

assign ev = {arith_ev, trap_nxt, ovf | unf};

always @(posedge aclk) begin
    if (!aresetn) begin
        sw_r <= 16'h0000;
        cw_r <= `CW_INIT;
        tag_r <= `TAG_ALL_EMPTY;
        done_r <= 1'b0;
        trap_r <= 1'b0;
        indef_r <= 1'b0;
        indef_kind_r <= 2'h0;
        store_r <= 1'b0;
    end else begin
        sw_r <= sw_nxt;
        cw_r <= cw_nxt;
        tag_r <= tag_nxt;
        done_r <= instr_valid;
        trap_r <= trap_nxt;
        indef_r <= indef_nxt;
        if (indef_nxt) begin
            indef_kind_r <= instr_dest_kind;
        end
        store_r <= store_nxt;
    end
end

// ----------------------------------------
// interrupt status, clear and enable
// ----------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        irq_stat_r <= {`IRQ_W{1'b0}};
        irq_en_r <= {`IRQ_W{1'b0}};
        irq_r <= 1'b0;
    end else begin
        // a new event beats a clear in the same cycle
        irq_stat_r <= (irq_stat_r & ~(wr_clr ? wdata_r[`IRQ_W-1:0] : {`IRQ_W{1'b0}})) | ev;
        if (wr_en) begin
            irq_en_r <= wdata_r[`IRQ_W-1:0];
        end
        irq_r <= |(irq_stat_r & irq_en_r);
    end
end

// ----------------------------------------
// bus slave
// ----------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        awready_r <= 1'b1;
        wready_r <= 1'b1;
        bvalid_r <= 1'b0;
        bresp_r <= `RESP_OKAY;
        arready_r <= 1'b1;
        rvalid_r <= 1'b0;
        rresp_r <= `RESP_OKAY;
        rdata_r <= 32'h00000000;
        aw_addr_r <= {ADDR_W{1'b0}};
        ar_addr_r <= {ADDR_W{1'b0}};
        wdata_r <= 32'h00000000;
        wstrb_r <= 4'h0;
    end else begin
        if (awvalid && awready_r) begin
            awready_r <= 1'b0;
            aw_addr_r <= awaddr;
        end
        if (wvalid && wready_r) begin
            wready_r <= 1'b0;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
        end
        if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
        end
        if (arvalid && arready_r) begin
            arready_r <= 1'b0;
            ar_addr_r <= araddr;
        end
        if (rd_go) begin
            rvalid_r <= 1'b1;
            rresp_r <= `RESP_OKAY;
            case (ar_addr_r)
                `REG_STATUS: rdata_r <= {16'h0000, sw_r};
                `REG_CONTROL: rdata_r <= {16'h0000, cw_r};
                `REG_TAGS: rdata_r <= {16'h0000, tag_r};
                `REG_IRQ_STAT: rdata_r <= {{(32-`IRQ_W){1'b0}}, irq_stat_r};
                `REG_IRQ_CLR: rdata_r <= 32'h00000000;
                `REG_IRQ_EN: rdata_r <= {{(32-`IRQ_W){1'b0}}, irq_en_r};
                default: begin
                    rdata_r <= 32'h00000000;
                    rresp_r <= `RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end
end

assign awready = awready_r;
assign wready = wready_r;
assign bvalid = bvalid_r;
assign bresp = bresp_r;
assign arready = arready_r;
assign rvalid = rvalid_r;
assign rresp = rresp_r;
assign rdata = rdata_r;
assign instr_done = done_r;
assign trap_req = trap_r;
assign indef_write = indef_r;
assign indef_kind = indef_kind_r;
assign store_valid = store_r;
assign store_cw = cw_r;
assign store_sw = sw_r;
assign store_tag = tag_r;
assign status_word = sw_r;
assign control_word = cw_r;
assign tag_word = tag_r;
assign irq = irq_r;

endmodule // fpu_exc_unit
`default_nettype wire

/* src/fpu_exc_regs.vh */
// Contract
// - three legacy opcodes act as pure no-ops
// - six exception flags, six matching mask bits
// - summary flag set while any unmasked flag
// - masks loadable/storable; flags storable by save ops
// - only arithmetic ops raise operand exceptions
// - invalid flag status bit 0, mask bit 0
// - stack-fault flag one means overflow/underflow
// - stack-fault flag never cleared by operand fault
// - overflow: memory load into non-empty register
// - underflow: empty register used as source
// - eight-entry register stack wraps around
// - stack fault sets invalid and stack-fault flags
// - condition bit one: overflow 1, underflow 0
// - masked stack fault writes indefinite value
// - unmasked stack fault traps, stack top and tags untouched
// - non-waiting ops never interrupted by pending exceptions
// - waiting ops service pending unmasked exceptions first
`ifndef FPU_EXC_REGS_VH
`define FPU_EXC_REGS_VH

// ----------------------------------------
// status and control word fields
// ----------------------------------------
`define SW_IE_BIT 0
`define SW_SF_BIT 6
`define SW_ES_BIT 7
`define SW_C1_BIT 9
`define SW_TOP_LO 11
`define CW_IM_BIT 0
`define CW_INIT 16'h003F
`define EXC_CLASSES 6

// ----------------------------------------
// register tags
// ----------------------------------------
`define TAG_VALID 2'h0
`define TAG_ZERO 2'h1
`define TAG_SPECIAL 2'h2
`define TAG_EMPTY 2'h3
`define TAG_ALL_EMPTY 16'hFFFF

// ----------------------------------------
// operation codes
// ----------------------------------------
`define OP_NOP 5'h00
`define OP_LDCW 5'h01
`define OP_STCW 5'h02
`define OP_STSW 5'h03
`define OP_SAVE 5'h04
`define OP_XSAVE 5'h05
`define OP_RSTOR 5'h06
`define OP_XRSTOR 5'h07
`define OP_CLEX 5'h08
`define OP_INIT 5'h09
`define OP_LEG_ENI 5'h0A
`define OP_LEG_DISI 5'h0B
`define OP_LEG_PM 5'h0C
`define OP_LOAD_EXT 5'h0D
`define OP_LOAD_FP 5'h0E
`define OP_STP_EXT 5'h0F
`define OP_STP_FP 5'h10
`define OP_ARITH 5'h11
`define OP_FREE 5'h12
`define OP_WAIT 5'h13
`define OP_XCHG 5'h14

// ----------------------------------------
// bus map and interrupt bits
// ----------------------------------------
`define REG_STATUS 8'h00
`define REG_CONTROL 8'h04
`define REG_TAGS 8'h08
`define REG_IRQ_STAT 8'h0C
`define REG_IRQ_CLR 8'h10
`define REG_IRQ_EN 8'h14
`define IRQ_STACK_FAULT 0
`define IRQ_TRAP 1
`define IRQ_UNMASKED 2
`define IRQ_W 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* verification/fpu_exc_unit_sva.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fpu_exc_regs.vh"
module fpu_exc_unit_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic instr_valid,
    input wire logic [4:0] instr_op,
    input wire logic instr_wait,
    input wire logic [1:0] instr_dest_kind,
    input wire logic trap_req,
    input wire logic indef_write,
    input wire logic [1:0] indef_kind,
    input wire logic store_valid,
    input wire logic [15:0] store_sw,
    input wire logic [15:0] status_word,
    input wire logic [15:0] control_word,
    input wire logic [15:0] tag_word
);
    // ----
    // helpers
    // ----
    wire logic [2:0] top = status_word[13:11];
    wire logic [2:0] tm1 = top - 3'h1;
    wire logic [1:0] t_top = tag_word[{top, 1'b0} +: 2];
    wire logic [1:0] t_below = tag_word[{tm1, 1'b0} +: 2];
    // waiting ops may trap instead, so only non-waiting ones here
    wire logic go = instr_valid && !instr_wait;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----
    // assertions
    // ----
    AST_LEGACY_NOP: assert property (
        instr_valid && instr_op inside {`OP_LEG_ENI, `OP_LEG_DISI, `OP_LEG_PM}
        |=> !trap_req && !indef_write && !store_valid && $stable(status_word)
        && $stable(control_word) && $stable(tag_word)) else $error("legacy op acted");
    AST_SUMMARY: assert property (
        $stable(status_word[5:0]) && $stable(control_word[5:0])
        |-> status_word[7] == |(status_word[5:0] & ~control_word[5:0]))
        else $error("summary flag wrong");
    AST_STICKY: assert property (
        |($past(status_word[6:0]) & ~status_word[6:0]) |-> $past(instr_valid)
        && $past(instr_op) inside {`OP_CLEX, `OP_INIT, `OP_RSTOR, `OP_XRSTOR})
        else $error("flag dropped");
    AST_OVF_MASKED: assert property (
        go && instr_op == `OP_LOAD_FP && t_below != `TAG_EMPTY && control_word[0]
        |=> indef_write && !trap_req && indef_kind == $past(instr_dest_kind)
        && status_word[9] && status_word[6] && status_word[0]) else $error("bad overflow");
    AST_UNF: assert property (
        go && instr_op == `OP_STP_FP && t_top == `TAG_EMPTY
        |=> !status_word[9] && status_word[6] && status_word[0]) else $error("bad underflow");
    AST_TRAP_KEEP: assert property (
        go && instr_op == `OP_STP_FP && t_top == `TAG_EMPTY && !control_word[0]
        |=> trap_req && !indef_write && $stable(tag_word) && $stable(status_word[13:11]))
        else $error("trap changed stack");
    AST_WAIT_TRAP: assert property (
        instr_valid && instr_wait && status_word[7] |=> trap_req && !store_valid)
        else $error("waiting op ran");
    AST_NOWAIT_STORE: assert property (
        go && instr_op == `OP_STSW |=> !trap_req && store_valid
        && store_sw == $past(status_word)) else $error("non-waiting store");
    AST_NONARITH: assert property (
        go && instr_op == `OP_NOP |=> $stable(status_word)) else $error("nop raised flags");
    CVR_INDEF: cover property (indef_write);
    CVR_TRAP: cover property (trap_req);
    CVR_STORE: cover property (store_valid);
endmodule // fpu_exc_unit_sva
bind fpu_exc_unit fpu_exc_unit_sva i_fpu_exc_unit_sva (.aclk, .aresetn, .instr_valid,
    .instr_op, .instr_wait, .instr_dest_kind, .trap_req, .indef_write, .indef_kind,
    .store_valid, .store_sw, .status_word, .control_word, .tag_word);
`default_nettype wire

/* verification/fpu_exc_unit_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fpu_exc_regs.vh"
module fpu_exc_unit_tb_top;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic instr_valid = 1'h0, instr_wait = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [4:0] instr_op = 5'h00;
    logic [1:0] instr_dest_kind = 2'h1;
    logic [5:0] arith_exc = 6'h00;
    logic [15:0] load_cw = 16'h003F;
    logic [15:0] load_sw = 16'h0000, load_tag = 16'h0000;
    logic [2:0] instr_sti = 3'h0;
    wire logic instr_done;
    wire logic awready, wready, bvalid, arready, rvalid, trap_req, indef_write, store_valid, irq;
    wire logic [1:0] bresp, rresp, indef_kind;
    wire logic [31:0] rdata;
    wire logic [15:0] store_cw, store_sw, store_tag, status_word, control_word, tag_word;
    logic tr, iw, sv;
    int fails = 0;
    int n_tests = 0;
    fpu_exc_unit i_fpu_exc_unit (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .instr_valid, .instr_op,
        .instr_sti, .instr_wait, .instr_dest_kind, .arith_exc, .load_cw,
        .load_sw, .load_tag, .instr_done, .trap_req, .indef_write,
        .indef_kind, .store_valid, .store_cw, .store_sw, .store_tag, .status_word,
        .control_word, .tag_word, .irq);
    always #20 aclk = ~aclk;
    // ----
    // common tasks
    // ----
    task end_of_test;
        $display("tests=%0d fails=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        n_tests++;
        if (g !== e) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
            fails++;
        end
    endtask
    task tmo(input int k);
        if (k >= 99) begin
            fails++;
            end_of_test;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        int k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (k = 0; k < 99; k++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        tmo(k);
        chk(bresp, er);
        bready <= 1'h0;
    endtask
    task rd_chk(input [7:0] a, input [31:0] e, input [1:0] er);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (k = 0; k < 99; k++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        tmo(k);
        chk(rdata, e);
        chk(rresp, er);
        rready <= 1'h0;
    endtask
    // pulses are caught just after the edge that follows the request
    task op(input [4:0] o, input w, input [5:0] e);
        @(posedge aclk);
        instr_valid <= 1'h1;
        instr_op <= o;
        instr_wait <= w;
        arith_exc <= e;
        @(posedge aclk);
        instr_valid <= 1'h0;
        #1;
        tr = trap_req;
        iw = indef_write;
        sv = store_valid;
    endtask
    // ----
    // scenarios
    // ----
    task s_reset;
        chk(status_word, 16'h0000);
        chk(control_word, `CW_INIT);
        chk(tag_word, `TAG_ALL_EMPTY);
        rd_chk(`REG_CONTROL, 32'h0000003F, `RESP_OKAY);
        rd_chk(8'h40, 32'h00000000, `RESP_SLVERR);
        wr(`REG_STATUS, 32'h0000FFFF, `RESP_OKAY);
        chk(status_word, 16'h0000);
        wr(`REG_IRQ_EN, 32'h00000007, `RESP_OKAY);
    endtask
    task s_overflow;
        int k;
        for (k = 0; k < 8; k++) op(`OP_LOAD_FP, 1'h0, 6'h00);
        chk(iw, 1'h0);
        @(posedge aclk) instr_dest_kind <= 2'h2;
        op(`OP_LOAD_FP, 1'h0, 6'h00);
        chk({iw, tr}, 2'h2);
        chk(indef_kind, 2'h2);
        chk(status_word, 16'h3A41);
        chk(tag_word, 16'h8000);
        @(posedge aclk);
        #1 chk(irq, 1'h1);
        wr(`REG_IRQ_CLR, 32'h00000001, `RESP_OKAY);
        rd_chk(`REG_IRQ_STAT, 32'h00000000, `RESP_OKAY);
        chk(irq, 1'h0);
    endtask
    task s_underflow;
        int k;
        op(`OP_INIT, 1'h0, 6'h00);
        op(`OP_STP_FP, 1'h0, 6'h00);
        chk(iw, 1'h1);
        chk(status_word, 16'h0841);
        op(`OP_LOAD_FP, 1'h0, 6'h00);
        op(`OP_ARITH, 1'h0, 6'h05);
        chk(status_word & 16'h38FF, 16'h0045);
        op(`OP_NOP, 1'h0, 6'h3A);
        for (k = 0; k < 3; k++) op(`OP_LEG_ENI + 5'(k), 1'h0, 6'h3A);
        chk(instr_done, 1'h1);
        chk(status_word & 16'h38FF, 16'h0045);
        chk(tag_word, 16'hFFFC);
        op(`OP_CLEX, 1'h0, 6'h00);
        chk(status_word & 16'h38FF, 16'h0000);
    endtask
    task s_trap;
        op(`OP_INIT, 1'h0, 6'h00);
        wr(`REG_CONTROL, 32'h0000003E, `RESP_OKAY);
        rd_chk(`REG_CONTROL, 32'h0000003E, `RESP_OKAY);
        op(`OP_STP_FP, 1'h0, 6'h00);
        chk({tr, iw}, 2'h2);
        chk(status_word, 16'h00C1);
        chk(tag_word, `TAG_ALL_EMPTY);
        op(`OP_STSW, 1'h1, 6'h00);
        chk({tr, sv}, 2'h2);
        op(`OP_STSW, 1'h0, 6'h00);
        chk({tr, sv}, 2'h1);
        chk(store_sw, 16'h00C1);
        op(`OP_STCW, 1'h0, 6'h00);
        chk(store_cw, 16'h003E);
        rd_chk(`REG_IRQ_STAT, 32'h00000003, `RESP_OKAY);
        chk(irq, 1'h1);
        wr(`REG_IRQ_EN, 32'h00000000, `RESP_OKAY);
        @(posedge aclk);
        #1 chk(irq, 1'h0);
        op(`OP_LDCW, 1'h0, 6'h00);
        chk(control_word, 16'h003F);
        chk(status_word[7], 1'h0);
        wr(`REG_IRQ_CLR, 32'h00000003, `RESP_OKAY);
    endtask
    // restore, wait, exchange, free, save and extended load paths
    task s_restore;
        @(posedge aclk);
        load_cw <= 16'h003D;
        load_sw <= 16'h0002;
        load_tag <= 16'hFFFC;
        instr_sti <= 3'h1;
        op(`OP_RSTOR, 1'h0, 6'h00);
        chk(status_word, 16'h0082);
        chk(control_word, 16'h003D);
        op(`OP_WAIT, 1'h0, 6'h00);
        chk(tr, 1'h1);
        op(`OP_XCHG, 1'h0, 6'h00);
        chk({iw, tr}, 2'h2);
        chk(tag_word, 16'hFFF2);
        chk(status_word, 16'h00C3);
        op(`OP_FREE, 1'h0, 6'h3F);
        chk(status_word, 16'h00C3);
        op(`OP_SAVE, 1'h0, 6'h00);
        chk({sv, tr}, 2'h2);
        chk(store_tag, 16'hFFFE);
        op(`OP_LOAD_EXT, 1'h0, 6'h3F);
        chk(status_word, 16'h38C3);
        op(`OP_ARITH, 1'h0, 6'h02);
        chk(status_word, 16'h38C3);
        rd_chk(`REG_TAGS, 32'h00003FFE, `RESP_OKAY);
        rd_chk(`REG_IRQ_STAT, 32'h00000007, `RESP_OKAY);
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        s_reset;
        s_overflow;
        s_underflow;
        s_trap;
        s_restore;
        end_of_test;
    end
endmodule // fpu_exc_unit_tb_top
`default_nettype wire
